// *** erpsc_pkg.sv ***
// Purpose: shared constants for the e1 receive payload / signaling unit
// Assumes: 8-bit register port, one core clock
// Notes: OFS_ offsets are the byte addresses of the device register port; HOFS_ ones are the controller's own
package erpsc_pkg;
   // ************
   // device register offsets
   // ************
   localparam logic [7:0] OFS_PAY_STATE = 8'hcd;
   localparam logic [7:0] OFS_PAY_CMD = 8'hce;
   localparam logic [7:0] OFS_PAY_BYTE = 8'hcf;
   localparam logic [7:0] OFS_PAY_SETUP = 8'hd0;
   localparam logic [7:0] OFS_PAY_ON = 8'hd1;
   localparam logic [7:0] OFS_SIG_SETUP = 8'hd2;
   localparam logic [7:0] OFS_SIG_STATE = 8'hd3;
   localparam logic [7:0] OFS_SIG_CMD = 8'hd4;
   localparam logic [7:0] OFS_SIG_BYTE = 8'hd5;
   localparam logic [7:0] OFS_FLAGS0 = 8'hd6;
   localparam logic [7:0] OFS_FLAGS3 = 8'hd9;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // ************
   // field positions
   // ************
   localparam int BIT_DIR = 7;      // access_direction, 1 = read
   localparam int BIT_BUSY = 0;
   localparam int BIT_SNAP = 7;     // signaling_snapshot_on
   localparam int BIT_GTRUNK = 6;   // global_signal_trunk_on
   localparam int BIT_FREEZE = 3;
   localparam int BIT_DEB = 2;      // signal_debounce_on
   localparam int BIT_IRQ_ON = 1;   // signal_change_irq_on
   localparam int BIT_TS_TRUNK = 4; // timeslot_signal_trunk_on
   localparam logic [6:0] IND_TRUNK_BASE = 7'h20;
   localparam logic [6:0] IND_SIG_BASE = 7'h40;
   localparam logic [4:0] TS_SIGNAL = 5'd16;
   localparam int NUM_FLAGS = 30;
   // ************
   // replacement codes and milliwatt sequences
   // ************
   localparam logic [2:0] SEL_NONE = 3'h0;
   localparam logic [2:0] SEL_TRUNK = 3'h1;
   localparam logic [2:0] SEL_ALAW = 3'h2;
   localparam logic [2:0] SEL_ULAW = 3'h3;
   localparam logic [63:0] MW_ALAW = 64'h342121_34b4a1a1b4;
   localparam logic [63:0] MW_ULAW = 64'h1e0b0b1e9e8b8b9e;
   // ************
   // stream buffer
   // ************
   localparam int FIFO_W = 19;
   localparam int FIFO_D = 8;
   // ************
   // host own registers
   // ************
   localparam logic [7:0] HOFS_DATA = 8'h00;
   localparam logic [7:0] HOFS_ADDR = 8'h01;
   localparam logic [7:0] HOFS_GO = 8'h02;
   localparam logic [7:0] HOFS_STATE = 8'h03;
   localparam logic [7:0] HOFS_RESULT = 8'h04;
   localparam int GO_READ = 0;
   localparam int GO_IND = 1;
   localparam int GO_SIG = 2;
endpackage

// *** erpsc_if.sv ***
// Purpose: register port joining the controller and the receive unit
// Assumes: one core clock, read data one cycle after the read strobe
// Notes: irq is the unit's interrupt level
`timescale 1ns/1ns
interface erpsc_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic irq;
   modport dev (input addr, input wdata, input wr, input rd,
      output rdata, output irq);
   modport host (output addr, output wdata, output wr, output rd,
      input rdata, input irq);
endinterface

// *** erpsc_fifo.sv ***
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: W and D set by the user, D a power of two
// Notes: in_ready is registered so it never depends on out_ready
`timescale 1ns/1ns
module erpsc_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [0:D-1];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic [AW:0] cnt_nxt;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // count tracks occupancy; ready is low only while the buffer holds D words and from reset to the first clock edge after it
   assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   // pointers and storage
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         in_ready <= 1'b0;
      end else begin
         if (push) begin
            mem[wp_r] <= in_data;
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_nxt;
         in_ready <= (cnt_nxt != (AW+1)'(D));
      end
   end
endmodule

// *** erpsc_device.sv ***
// Purpose: receive payload control and receive signaling buffer, one E1
// Assumes: timeslot words arrive in order with their ABCD nibble
// Notes: indirect transfers take one cycle; busy shows for that cycle
`timescale 1ns/1ns
module erpsc_device
   import erpsc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   erpsc_if.dev bus,
   input wire logic s_valid,
   output logic s_ready,
   input wire logic [4:0] s_ts,
   input wire logic [7:0] s_data,
   input wire logic [3:0] s_abcd,
   input wire logic s_first,
   input wire logic s_sync,
   output logic m_valid,
   input wire logic m_ready,
   output logic [7:0] m_data,
   output logic [3:0] m_sig
);
   // ************
   // state
   // ************
   logic [7:0] pay_cmd_r, pay_byte_r, pay_setup_r, sig_setup_r;
   logic [7:0] sig_cmd_r, sig_byte_r;
   logic pay_on_r, pay_busy_r, sig_busy_r;
   logic [7:0] pay_mem [0:127];
   logic [3:0] sig_mem [0:31];
   logic [3:0] last_mem [0:31];
   logic [3:0] snap_mem [0:31];
   logic [NUM_FLAGS-1:0] flag_r;
   logic [2:0] mw_phase_r;
   logic [FIFO_W-1:0] f_data;
   logic f_valid;

   // timeslot to change flag index; slots 0 and 16 have none
   function automatic logic [4:0] ts_to_flag(input logic [4:0] ts);
      ts_to_flag = (ts > TS_SIGNAL) ? ts - 5'd2 : ts - 5'd1;
   endfunction

   // ************
   // stream buffer
   // ************
   wire pop = f_valid && (!m_valid || m_ready);
   erpsc_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
      .core_clk(core_clk),
      .rstn(rstn),
      .in_valid(s_valid),
      .in_ready(s_ready),
      .in_data({s_first, s_sync, s_ts, s_abcd, s_data}),
      .out_valid(f_valid),
      .out_ready(pop),
      .out_data(f_data)
   );

   // ************
   // per-word decode
   // ************
   wire h_first = f_data[18];
   wire h_sync = f_data[17];
   wire [4:0] h_ts = f_data[16:12];
   wire [3:0] h_abcd = f_data[11:8];
   wire [7:0] h_data = f_data[7:0];
   wire [7:0] ts_cfg = pay_mem[{2'b00, h_ts}];
   wire [7:0] ts_trunk = pay_mem[IND_TRUNK_BASE | {2'b00, h_ts}];
   wire [7:0] ts_sig = pay_mem[IND_SIG_BASE | {2'b00, h_ts}];
   wire [2:0] gsel = pay_setup_r[2:0];
   wire [2:0] sel = (gsel == SEL_NONE) ? ts_cfg[7:5] : gsel;
   wire [7:0] mw_a = MW_ALAW[8*(7-mw_phase_r) +: 8];
   wire [7:0] mw_u = MW_ULAW[8*(7-mw_phase_r) +: 8];
   // reserved codes leave the data untouched
   wire [7:0] data_rep = (sel == SEL_TRUNK) ? ts_trunk :
      (sel == SEL_ALAW) ? mw_a :
      (sel == SEL_ULAW) ? mw_u : h_data;
   wire snap_act = pay_setup_r[BIT_SNAP] && h_sync;
   wire [3:0] sig_src = (snap_act && !h_first) ?
      snap_mem[h_ts] : h_abcd;
   wire trunk = pay_setup_r[BIT_GTRUNK] || ts_sig[BIT_TS_TRUNK];
   wire [3:0] sig_rep = trunk ? ts_sig[3:0] : sig_src;
   wire has_sig = (h_ts != 5'd0) && (h_ts != TS_SIGNAL);
   wire deb_ok = !sig_setup_r[BIT_DEB] || (last_mem[h_ts] == h_abcd);
   wire sig_upd = pop && has_sig && !sig_setup_r[BIT_FREEZE]
      && deb_ok;
   wire sig_chg = sig_upd && (sig_mem[h_ts] != h_abcd);
   wire [4:0] fidx = ts_to_flag(h_ts);

   // ************
   // register port decode
   // ************
   wire wr_pay_cmd = bus.wr && bus.addr == OFS_PAY_CMD;
   wire wr_sig_cmd = bus.wr && bus.addr == OFS_SIG_CMD;
   wire pay_rd = pay_cmd_r[BIT_DIR];
   wire sig_rd = sig_cmd_r[BIT_DIR];
   wire [6:0] pay_a = pay_cmd_r[6:0];
   wire [4:0] sig_a = sig_cmd_r[4:0];
   wire [7:0] flag_wr_mask = (bus.addr >= OFS_FLAGS0 &&
      bus.addr <= OFS_FLAGS3 && bus.wr) ? bus.wdata : 8'h00;
   logic [31:0] clr_vec;
   assign clr_vec = 32'(flag_wr_mask) << (8*(bus.addr - OFS_FLAGS0));
   logic [31:0] flag_ext;
   assign flag_ext = {2'b00, flag_r};
   logic [7:0] rd_mux;
   always_comb begin
      unique case (bus.addr)
         OFS_PAY_STATE: rd_mux = {7'h00, pay_busy_r};
         OFS_PAY_CMD: rd_mux = pay_cmd_r;
         OFS_PAY_BYTE: rd_mux = pay_byte_r;
         OFS_PAY_SETUP: rd_mux = pay_setup_r & 8'hc7;
         OFS_PAY_ON: rd_mux = {7'h00, pay_on_r};
         OFS_SIG_SETUP: rd_mux = sig_setup_r & 8'h0e;
         OFS_SIG_STATE: rd_mux = {7'h00, sig_busy_r};
         OFS_SIG_CMD: rd_mux = sig_cmd_r;
         OFS_SIG_BYTE: rd_mux = sig_byte_r;
         OFS_FLAGS0: rd_mux = flag_ext[7:0];
         OFS_FLAGS0 + 8'h01: rd_mux = flag_ext[15:8];
         OFS_FLAGS3 - 8'h01: rd_mux = flag_ext[23:16];
         OFS_FLAGS3: rd_mux = flag_ext[31:24];
         default: rd_mux = 8'h00;
      endcase
   end

   // ************
   // direct registers and indirect sequencing
   // ************
   // busy lasts one cycle: the transfer is done the cycle after the
   // command, so a processor that polls never sees a stale byte
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pay_cmd_r <= RESET_BYTE;
         pay_byte_r <= RESET_BYTE;
         pay_setup_r <= RESET_BYTE;
         pay_on_r <= 1'b0;
         sig_setup_r <= RESET_BYTE;
         sig_cmd_r <= RESET_BYTE;
         sig_byte_r <= RESET_BYTE;
         pay_busy_r <= 1'b0;
         sig_busy_r <= 1'b0;
         bus.rdata <= RESET_BYTE;
         bus.irq <= 1'b0;
      end else begin
         bus.rdata <= bus.rd ? rd_mux : RESET_BYTE;
         bus.irq <= sig_setup_r[BIT_IRQ_ON] && (flag_r != '0);
         if (bus.wr && bus.addr == OFS_PAY_SETUP) pay_setup_r <= bus.wdata;
         if (bus.wr && bus.addr == OFS_PAY_ON) pay_on_r <= bus.wdata[0];
         if (bus.wr && bus.addr == OFS_SIG_SETUP) sig_setup_r <= bus.wdata;
         if (wr_pay_cmd) pay_cmd_r <= bus.wdata;
         if (wr_sig_cmd) sig_cmd_r <= bus.wdata;
         pay_busy_r <= wr_pay_cmd;
         sig_busy_r <= wr_sig_cmd;
         if (pay_busy_r && pay_rd) begin
            pay_byte_r <= pay_mem[pay_a];
         end else if (bus.wr && bus.addr == OFS_PAY_BYTE) begin
            pay_byte_r <= bus.wdata;
         end
         if (sig_busy_r && sig_rd) begin
            sig_byte_r <= {4'h0, sig_mem[sig_a]};
         end else if (bus.wr && bus.addr == OFS_SIG_BYTE) begin
            sig_byte_r <= bus.wdata;
         end
      end
   end

   // payload indirect store, written from the held data byte
   always_ff @(posedge core_clk) begin
      if (pay_busy_r && !pay_rd) pay_mem[pay_a] <= pay_byte_r;
   end

   // ************
   // signaling buffer
   // ************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 32; i++) begin
            sig_mem[i] <= 4'h0;
            last_mem[i] <= 4'h0;
            snap_mem[i] <= 4'h0;
         end
      end else begin
         if (pop) last_mem[h_ts] <= h_abcd;
         if (pop && h_first) snap_mem[h_ts] <= h_abcd;
         if (sig_busy_r && !sig_rd) begin
            sig_mem[sig_a] <= sig_byte_r[3:0];
         end else if (sig_upd) begin
            sig_mem[h_ts] <= h_abcd;
         end
      end
   end

   // change flags: a new change wins over a same-cycle clear
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flag_r <= '0;
      end else begin
         flag_r <= (flag_r & ~clr_vec[NUM_FLAGS-1:0])
            | (NUM_FLAGS'(sig_chg) << fidx);
      end
   end

   // ************
   // output stage
   // ************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         m_valid <= 1'b0;
         m_data <= 8'h00;
         m_sig <= 4'h0;
         mw_phase_r <= 3'h0;
      end else begin
         if (pop || m_ready) m_valid <= pop;
         if (pop) begin
            mw_phase_r <= mw_phase_r + 3'h1;
            m_data <= pay_on_r ? data_rep : h_data;
            m_sig <= pay_on_r ? sig_rep : h_abcd;
         end
      end
   end
endmodule

// *** erpsc_host.sv ***
// Purpose: controller that drives the unit's register port for software
// Assumes: software waits for done before a new go
// Notes: indirect writes load the data byte before the command; indirect reads poll busy before fetching it
`timescale 1ns/1ns
module erpsc_host
   import erpsc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   erpsc_if.host bus,
   input wire logic [7:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [7:0] sw_rdata
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b000, H_LOAD = 3'b001, H_CMD = 3'b010, H_POLL = 3'b011,
      H_CHK = 3'b100, H_FETCH = 3'b101, H_GRAB = 3'b110
   } erpsc_hstate_type;
   erpsc_hstate_type st_r;
   logic [7:0] data_r, addr_r, result_r;
   logic [2:0] go_r;
   logic done_r;
   wire go = sw_wr && sw_addr == HOFS_GO && st_r == H_IDLE;
   wire [7:0] ctrl_ofs = go_r[GO_SIG] ? OFS_SIG_CMD : OFS_PAY_CMD;
   wire [7:0] byte_ofs = go_r[GO_SIG] ? OFS_SIG_BYTE : OFS_PAY_BYTE;
   wire [7:0] stat_ofs = go_r[GO_SIG] ? OFS_SIG_STATE : OFS_PAY_STATE;
   wire finish = (st_r == H_GRAB && !bus.rd) || (st_r == H_CHK &&
      !bus.rd && !bus.rdata[BIT_BUSY] && !go_r[GO_READ]) ||
      (st_r == H_CMD && !go_r[GO_IND] && !go_r[GO_READ]);
   logic [7:0] sw_mux;
   assign sw_mux = (sw_addr == HOFS_DATA) ? data_r :
      (sw_addr == HOFS_ADDR) ? addr_r :
      (sw_addr == HOFS_STATE) ?
         {5'h00, bus.irq, done_r, st_r != H_IDLE} :
      (sw_addr == HOFS_RESULT) ? result_r : 8'h00;

   // software side registers; done set wins over its clear
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         data_r <= 8'h00;
         addr_r <= 8'h00;
         go_r <= 3'h0;
         done_r <= 1'b0;
         result_r <= 8'h00;
         sw_rdata <= 8'h00;
      end else begin
         sw_rdata <= sw_rd ? sw_mux : 8'h00;
         if (sw_wr && sw_addr == HOFS_DATA) data_r <= sw_wdata;
         if (sw_wr && sw_addr == HOFS_ADDR) addr_r <= sw_wdata;
         if (go) go_r <= sw_wdata[2:0];
         if (st_r == H_GRAB && !bus.rd) result_r <= bus.rdata;
         done_r <= finish ||
            (done_r && !(sw_wr && sw_addr == HOFS_STATE && sw_wdata[1]));
      end
   end

   // sequencer: a read state waits out its strobe cycle for the data
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= H_IDLE;
         bus.addr <= 8'h00;
         bus.wdata <= 8'h00;
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
      end else begin
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
         unique case (st_r)
            H_IDLE: if (go) st_r <= H_LOAD;
            H_LOAD: begin
               if (!go_r[GO_IND]) begin
                  bus.addr <= addr_r;
                  bus.wdata <= data_r;
                  bus.wr <= !go_r[GO_READ];
                  bus.rd <= go_r[GO_READ];
                  st_r <= go_r[GO_READ] ? H_GRAB : H_CMD;
               end else begin
                  bus.addr <= byte_ofs;
                  bus.wdata <= data_r;
                  bus.wr <= !go_r[GO_READ];
                  st_r <= H_CMD;
               end
            end
            H_CMD: begin
               if (go_r[GO_IND]) begin
                  bus.addr <= ctrl_ofs;
                  bus.wdata <= {go_r[GO_READ], addr_r[6:0]};
                  bus.wr <= 1'b1;
                  st_r <= H_POLL;
               end else begin
                  st_r <= H_IDLE;
               end
            end
            H_POLL: begin
               bus.addr <= stat_ofs;
               bus.rd <= 1'b1;
               st_r <= H_CHK;
            end
            H_CHK: if (!bus.rd) begin
               if (bus.rdata[BIT_BUSY]) st_r <= H_POLL;
               else if (go_r[GO_READ]) st_r <= H_FETCH;
               else st_r <= H_IDLE;
            end
            H_FETCH: begin
               bus.addr <= byte_ofs;
               bus.rd <= 1'b1;
               st_r <= H_GRAB;
            end
            H_GRAB: if (!bus.rd) st_r <= H_IDLE;
            default: st_r <= H_IDLE;
         endcase
      end
   end
endmodule

// *** erpsc_chk_sva.sv ***
// Purpose: assertions on the register port between controller and unit
// Assumes: one core clock, rstn asynchronous active low
// Notes: sees only the interface signals, instanced beside the interface
`timescale 1ns/1ns
module erpsc_chk_sva
   import erpsc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic irq
);
   // ************
   // decode
   // ************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // control writes and status reads of each unit
   wire pcmd = wr && addr == OFS_PAY_CMD;
   wire scmd = wr && addr == OFS_SIG_CMD;
   wire prd = rd && addr == OFS_PAY_STATE;
   wire srd = prd || (rd && addr == OFS_SIG_STATE);
   wire [6:0] ia = wdata[6:0];
   sequence pay_cmd_rd; pcmd && wdata[BIT_DIR]; endsequence
   sequence pay_byte_rd; rd && addr == OFS_PAY_BYTE; endsequence
   sequence poll_next; pcmd ##1 prd; endsequence
   sequence poll_late; pcmd ##[2:6] prd; endsequence
   // ************
   // properties
   // ************
   rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
      else $error("read data outside a read");
   busy_rsv_a: assert property (srd |=> rdata[7:1] == 7'h00)
      else $error("status reserved bits set");
   cmd_gap_a: assert property (pcmd |=> !pcmd [*2])
      else $error("control write while busy");
   busy_rise_a: assert property (poll_next |=> rdata[BIT_BUSY])
      else $error("busy not shown after control write");
   busy_fall_a: assert property (poll_late |=> !rdata[BIT_BUSY])
      else $error("busy still set");
   wr_order_a: assert property (pcmd && !wdata[BIT_DIR] |->
      $past(wr) && $past(addr) == OFS_PAY_BYTE) else $error("byte not first");
   sig_order_a: assert property (scmd && !wdata[BIT_DIR] |->
      $past(wr) && $past(addr) == OFS_SIG_BYTE) else $error("byte not first");
   rd_fetch_a: assert property (pay_cmd_rd |-> ##[2:30] pay_byte_rd)
      else $error("read result never fetched");
   pay_addr_a: assert property (pcmd |-> ia <= 7'h3f ||
      (ia > 7'h40 && ia <= 7'h5f && ia != 7'h50)) else $error("bad address");
   sig_addr_a: assert property (scmd |-> ia[3:0] != 4'h0 &&
      ia[6:5] == 2'h0) else $error("bad signaling address");
   irq_off_a: assert property (wr && addr == OFS_SIG_SETUP &&
      !wdata[BIT_IRQ_ON] |-> ##2 !irq) else $error("irq while disabled");
   setup_rsv_a: assert property (rd && addr == OFS_SIG_SETUP |=>
      (rdata & 8'hf1) == 8'h00) else $error("setup reserved bits set");
endmodule

// *** tb.sv ***
// Purpose: self-checking bench for controller and receive unit
// Assumes: 100 MHz core clock, reset held low for 4 cycles
// Notes: software port and both stream sides are driven here
`timescale 1ns/1ns
module tb
   import erpsc_pkg::*;
;
   // ************
   // signals and instances
   // ************
   logic core_clk, rstn, sw_wr, sw_rd, s_valid, s_ready, s_first, s_sync;
   logic m_valid, m_ready;
   logic [7:0] sw_addr, sw_wdata, sw_rdata, s_data, m_data, r;
   logic [4:0] s_ts;
   logic [3:0] s_abcd, m_sig;
   logic [11:0] w;
   logic [11:0] oq[$];
   int n_fail, cmp_count;
   erpsc_if bus();
   erpsc_host u_erpsc_host (.core_clk(core_clk), .rstn(rstn), .bus(bus),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
      .sw_rd(sw_rd), .sw_rdata(sw_rdata));
   erpsc_device u_erpsc_device (.core_clk(core_clk), .rstn(rstn),
      .bus(bus), .s_valid(s_valid), .s_ready(s_ready), .s_ts(s_ts),
      .s_data(s_data), .s_abcd(s_abcd), .s_first(s_first), .s_sync(s_sync),
      .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data), .m_sig(m_sig));
   erpsc_chk_sva u_erpsc_chk_sva (.core_clk(core_clk), .rstn(rstn),
      .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
      .rdata(bus.rdata), .irq(bus.irq));
   // free-running clock
   always #5 core_clk = ~core_clk;
   // collect accepted output words, sig above data
   always @(posedge core_clk) begin
      if (m_valid === 1'h1 && m_ready === 1'h1) oq.push_back({m_sig, m_data});
   end
   // ************
   // helpers
   // ************
   task check(input string nm, input logic [7:0] seen, input logic [7:0] e);
      cmp_count++;
      if (seen !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, seen);
      end
   endtask
   task complete_run;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one-cycle software strobes; read data lands the cycle after
   task sw(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'h1;
      @(posedge core_clk);
      sw_wr <= 1'h0;
   endtask
   task sr(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      sw_addr <= a;
      sw_rd <= 1'h1;
      @(posedge core_clk);
      sw_rd <= 1'h0;
      #1 d = sw_rdata;
   endtask
   // a controller order: load, go, poll done under a bound, clear, result
   task op(input logic [7:0] a, input logic [7:0] d, input logic [2:0] g);
      logic [7:0] s;
      int k;
      sw(HOFS_DATA, d);
      sw(HOFS_ADDR, a);
      sw(HOFS_GO, {5'h00, g});
      s = 8'h00;
      k = 0;
      while (s[1] !== 1'h1 && k < 40) begin
         sr(HOFS_STATE, s);
         k++;
      end
      check("done", {7'h00, s[1]}, 8'h01);
      sw(HOFS_STATE, 8'h02);
      sr(HOFS_RESULT, r);
   endtask
   task dw(input logic [7:0] a, input logic [7:0] d); op(a, d, 3'h0); endtask
   task dr(input logic [7:0] a); op(a, 8'h00, 3'h1); endtask
   task iw(input logic u, input logic [7:0] a, input logic [7:0] d);
      op(a, d, {u, 2'h2});
   endtask
   task ir(input logic u, input logic [7:0] a); op(a, 8'h00, {u, 2'h3}); endtask
   // one stream word in, wait for its processed word out
   task xf(input logic [4:0] t, input logic [7:0] d, input logic [3:0] a,
      input logic f);
      int k;
      @(posedge core_clk);
      s_valid <= 1'h1;
      s_ts <= t;
      s_data <= d;
      s_abcd <= a;
      s_first <= f;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (s_ready !== 1'h1 && k < 20);
      s_valid <= 1'h0;
      while (oq.size() == 0 && k < 60) begin
         @(posedge core_clk);
         k++;
      end
      w = (oq.size() > 0) ? oq.pop_front() : 12'hxxx;
   endtask
   // ************
   // scenarios
   // ************
   task t_regs;
      logic [7:0] al[8] = '{OFS_PAY_STATE, OFS_PAY_CMD, OFS_PAY_BYTE,
         OFS_PAY_SETUP, OFS_SIG_SETUP, OFS_FLAGS0, OFS_FLAGS3, 8'he0};
      foreach (al[i]) begin
         dr(al[i]);
         check("reset value", r, RESET_BYTE);
      end
      $display("test regs done");
   endtask
   // defined per-slot memory first: it has no reset
   task t_ind;
      logic [7:0] t;
      for (t = 8'h01; t < 8'h08; t++) begin
         iw(1'h0, t, 8'h00);
         iw(1'h0, 8'h20 + t, 8'h30 + t);
         iw(1'h0, 8'h40 + t, 8'h00);
      end
      ir(1'h0, 8'h23);
      check("indirect", r, 8'h33);
      iw(1'h1, 8'h11, 8'h0a);
      ir(1'h1, 8'h11);
      check("sig indirect", r & 8'h0f, 8'h0a);
      $display("test indirect done");
   endtask
   task t_data;
      dw(OFS_PAY_ON, 8'h01);
      dr(OFS_PAY_ON);
      check("enable", r, 8'h01);
      dw(OFS_PAY_SETUP, {5'h00, SEL_NONE});
      iw(1'h0, 8'h03, {SEL_TRUNK, 5'h00});
      xf(5'h03, 8'h77, 4'h0, 1'h0);
      check("slot trunk", w[7:0], 8'h33);
      xf(5'h02, 8'h77, 4'h0, 1'h0);
      check("slot pass", w[7:0], 8'h77);
      dw(OFS_PAY_SETUP, {5'h00, SEL_TRUNK});
      xf(5'h02, 8'h77, 4'h0, 1'h0);
      check("global trunk", w[7:0], 8'h32);
      dw(OFS_PAY_SETUP, 8'h05);
      xf(5'h02, 8'h77, 4'h0, 1'h0);
      check("reserved code", w[7:0], 8'h77);
      dw(OFS_PAY_SETUP, {5'h00, SEL_TRUNK});
      dw(OFS_PAY_ON, 8'h00);
      xf(5'h02, 8'h77, 4'h0, 1'h0);
      check("disabled", w[7:0], 8'h77);
      dw(OFS_PAY_ON, 8'h01);
      $display("test data done");
   endtask
   // phase advances on every output word in any mode, so accept any rotation of the pattern
   task t_mw;
      logic [7:0] b[8];
      logic [63:0] p;
      logic ok, hit;
      for (int m = 0; m < 2; m++) begin
         p = m ? MW_ULAW : MW_ALAW;
         dw(OFS_PAY_SETUP, {5'h00, m ? SEL_ULAW : SEL_ALAW});
         foreach (b[i]) begin
            xf(5'h01, 8'h00, 4'h0, 1'h0);
            b[i] = w[7:0];
         end
         ok = 1'h0;
         for (int k = 0; k < 8; k++) begin
            hit = 1'h1;
            foreach (b[i]) if (b[i] !== p[8*(7-(i+k)%8) +: 8]) hit = 1'h0;
            ok = ok | hit;
         end
         check("milliwatt", {7'h00, ok}, 8'h01);
      end
      $display("test milliwatt done");
   endtask
   task t_sig;
      dw(OFS_PAY_SETUP, 8'h00);
      iw(1'h0, 8'h45, 8'h1c);
      xf(5'h05, 8'h00, 4'h3, 1'h0);
      check("slot sig trunk", {4'h0, w[11:8]}, 8'h0c);
      xf(5'h06, 8'h00, 4'h3, 1'h0);
      check("sig pass", {4'h0, w[11:8]}, 8'h03);
      dw(OFS_PAY_SETUP, 8'h40);
      iw(1'h0, 8'h46, 8'h07);
      xf(5'h06, 8'h00, 4'h3, 1'h0);
      check("global sig trunk", {4'h0, w[11:8]}, 8'h07);
      dw(OFS_PAY_SETUP, 8'h80);
      s_sync <= 1'h1;
      xf(5'h04, 8'h00, 4'h6, 1'h1);
      xf(5'h04, 8'h00, 4'h9, 1'h0);
      check("snapshot", {4'h0, w[11:8]}, 8'h06);
      s_sync <= 1'h0;
      xf(5'h04, 8'h00, 4'h9, 1'h0);
      check("no sync", {4'h0, w[11:8]}, 8'h09);
      dw(OFS_PAY_SETUP, 8'h00);
      $display("test signaling done");
   endtask
   task t_flags;
      dw(OFS_SIG_SETUP, 8'hff);
      dr(OFS_SIG_SETUP);
      check("setup", r, 8'h0e);
      dw(OFS_SIG_SETUP, 8'h02);
      iw(1'h1, 8'h02, 8'h00);
      dw(OFS_FLAGS0, 8'hff);
      xf(5'h02, 8'h00, 4'h5, 1'h0);
      dr(OFS_FLAGS0);
      check("flag map", r, 8'h02);
      sr(HOFS_STATE, r);
      check("irq on", {7'h00, r[2]}, 8'h01);
      dw(OFS_FLAGS0, 8'h02);
      dr(OFS_FLAGS0);
      check("flag clear", r, 8'h00);
      ir(1'h1, 8'h02);
      check("stored", r & 8'h0f, 8'h05);
      dw(OFS_SIG_SETUP, 8'h00);
      xf(5'h02, 8'h00, 4'h6, 1'h0);
      sr(HOFS_STATE, r);
      check("irq masked", {7'h00, r[2]}, 8'h00);
      dw(OFS_FLAGS0, 8'hff);
      dw(OFS_SIG_SETUP, 8'h04);
      xf(5'h02, 8'h00, 4'h9, 1'h0);
      ir(1'h1, 8'h02);
      check("one word", r & 8'h0f, 8'h06);
      xf(5'h02, 8'h00, 4'h9, 1'h0);
      ir(1'h1, 8'h02);
      check("two words", r & 8'h0f, 8'h09);
      dw(OFS_SIG_SETUP, 8'h08);
      xf(5'h02, 8'h00, 4'h3, 1'h0);
      ir(1'h1, 8'h02);
      check("frozen", r & 8'h0f, 8'h09);
      dw(OFS_SIG_SETUP, 8'h00);
      iw(1'h1, 8'h11, 8'h00);
      dw(OFS_FLAGS0 + 8'h01, 8'hff);
      xf(5'h11, 8'h00, 4'hf, 1'h0);
      dr(OFS_FLAGS0 + 8'h01);
      check("slot 17 flag", r, 8'h80);
      $display("test flags done");
   endtask
   // output stalled: fill until refused, then drain in order
   task t_fifo;
      int c, k;
      dw(OFS_PAY_ON, 8'h00);
      @(posedge core_clk);
      m_ready <= 1'h0;
      s_valid <= 1'h1;
      s_data <= 8'h00;
      c = 0;
      repeat (12) begin
         @(posedge core_clk);
         if (s_ready === 1'h1) s_data <= 8'(++c);
      end
      s_valid <= 1'h0;
      check("depth", 8'(c), 8'(FIFO_D + 1));
      m_ready <= 1'h1;
      k = 0;
      while (oq.size() < c && k < 40) begin
         @(posedge core_clk);
         k++;
      end
      check("drained", 8'(oq.size()), 8'(c));
      foreach (oq[i]) check("order", oq[i][7:0], 8'(i));
      $display("test buffer done");
   endtask
   // ************
   // main sequence and watchdog
   // ************
   initial begin
      {core_clk, rstn, sw_wr, sw_rd, s_valid, s_first, s_sync} = 7'h00;
      {sw_addr, sw_wdata, s_data, s_ts, s_abcd} = 33'h0;
      m_ready = 1'h1;
      repeat (4) @(posedge core_clk);
      rstn <= 1'h1;
      t_regs;
      t_ind;
      t_data;
      t_mw;
      t_sig;
      t_flags;
      t_fifo;
      complete_run;
   end
   // some twenty-five times the expected run length
   initial begin
      #400000;
      n_fail++;
      complete_run;
   end
endmodule
